// ===== verilog/amc_pkg.sv
`default_nettype none
package amc_pkg;
  // ****************************************
  // timing counts, in master clocks
  // ****************************************
  localparam int unsigned SETTLE_CLOCKS = 32;
  localparam int unsigned CONV_CLOCKS   = 256;
  localparam int unsigned SAR_BITS      = 8;
  localparam int unsigned STEP_CLOCKS   = (CONV_CLOCKS - SETTLE_CLOCKS) / SAR_BITS;
  localparam logic [7:0]  SETTLE_LAST   = 8'(SETTLE_CLOCKS - 1);
  localparam logic [7:0]  STEP_LAST     = 8'(STEP_CLOCKS - 1);

  // ****************************************
  // register select and field positions
  // ****************************************
  localparam logic        SEL_RESULTS   = 1'b0;
  localparam logic        SEL_DISCRETE  = 1'b1;
  localparam int unsigned CTL_SC_BIT    = 7;
  localparam int unsigned CTL_DIR_BIT   = 6;
  localparam int unsigned STS_DONE_BIT  = 7;
  localparam int unsigned STS_BUSY_BIT  = 6;

  // ****************************************
  // reset values and the first trial code
  // ****************************************
  localparam logic [3:0]  CHAN_RESET    = 4'h0;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [7:0]  SAR_TOP       = 8'h80;

  // sequencer states
  typedef enum logic [1:0] {
    AMC_NOOP,
    AMC_SETTLE,
    AMC_CONVERT
  } amc_state_type;

  // host bus sample after the synchroniser
  typedef struct packed {
    logic       cs_n;
    logic       rd;
    logic       rsel;
    logic [7:0] data;
  } amc_bus_type;
endpackage
`default_nettype wire

// ===== verilog/amc_top.sv
`timescale 1ns/1ps
`default_nettype none
module amc_top
  import amc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // host bus pins
  input  wire logic       cs_n_in,
  input  wire logic       rd_nwr_in,
  input  wire logic       register_select_line_in,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe_out,
  // converter front end
  input  wire logic       comp_in,
  input  wire logic       neg_ge_pos_in,
  input  wire logic [5:0] dual_use_inputs_in,
  output logic      [3:0] chan_sel_out,
  output logic      [7:0] dac_code_out,
  output logic            settling_out,
  // peripheral port and status
  output logic      [7:0] port_data_out,
  output logic            port_oe_out,
  output logic            busy_out,
  output logic            done_out
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  amc_bus_type   bus_meta_ff;
  amc_bus_type   bus_ff;
  logic [7:0]    ana_meta_ff;
  logic [7:0]    ana_ff;
  wire  [7:0]    ana_pins = {comp_in, neg_ge_pos_in, dual_use_inputs_in};

  // two flops on every pin; only the second one is read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bus_meta_ff <= '{cs_n: 1'b1, rd: 1'b0, rsel: 1'b0, data: BYTE_ZERO};
      bus_ff      <= '{cs_n: 1'b1, rd: 1'b0, rsel: 1'b0, data: BYTE_ZERO};
      ana_meta_ff <= BYTE_ZERO;
      ana_ff      <= BYTE_ZERO;
    end else begin
      bus_meta_ff <= '{cs_n: cs_n_in, rd: rd_nwr_in, rsel: register_select_line_in,
                       data: host_data_bus_in};
      bus_ff      <= bus_meta_ff;
      ana_meta_ff <= ana_pins;
      ana_ff      <= ana_meta_ff;
    end
  end

  wire       comp_s     = ana_ff[7];
  wire       neg_ge_s   = ana_ff[6];
  wire [5:0] dual_use_s = ana_ff[5:0];

  // ****************************************
  // byte pointer and bus decode
  // ****************************************
  logic          lsb_ptr_ff;
  logic [7:0]    ctl_msb_ff;
  logic [3:0]    channel_ff;
  logic          dir_ff;
  logic          start_ff;
  logic          done_ff;
  logic          busy_ff;
  logic [7:0]    result_ff;

  wire bus_act    = !bus_ff.cs_n;
  wire wr_msb     = bus_act && !bus_ff.rd && !lsb_ptr_ff;
  wire wr_commit  = bus_act && !bus_ff.rd && lsb_ptr_ff;
  wire rd_act     = bus_act && bus_ff.rd;
  wire sc_written = wr_commit && bus_ff.data[CTL_SC_BIT];

  // read words; each one is live, no snapshot between bytes
  wire [15:0] results_word  = {done_ff, busy_ff, 6'h00, result_ff};
  wire [15:0] discrete_word = {2'h0, dual_use_s, 4'h0, channel_ff};
  wire [15:0] read_word     = (bus_ff.rsel == SEL_DISCRETE) ? discrete_word : results_word;
  wire [7:0]  read_byte     = lsb_ptr_ff ? read_word[7:0] : read_word[15:8];

  // pointer toggles per byte, falls back to msb once cs sits high a clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lsb_ptr_ff <= 1'b0;
    end else begin
      lsb_ptr_ff <= bus_act ? !lsb_ptr_ff : 1'b0;
    end
  end

  // control word: msb byte parked until the lsb byte commits it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctl_msb_ff    <= BYTE_ZERO;
      port_data_out <= BYTE_ZERO;
      channel_ff    <= CHAN_RESET;
      dir_ff        <= 1'b0;
    end else begin
      if (wr_msb) begin
        ctl_msb_ff <= bus_ff.data;
      end
      if (wr_commit) begin
        port_data_out <= ctl_msb_ff;
        channel_ff    <= bus_ff.data[3:0];
        dir_ff        <= bus_ff.data[CTL_DIR_BIT];
      end
    end
  end

  // read data is registered, so it leaves one clock after the byte is taken
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      host_data_bus_out    <= BYTE_ZERO;
      host_data_bus_oe_out <= 1'b0;
    end else begin
      host_data_bus_out    <= rd_act ? read_byte : BYTE_ZERO;
      host_data_bus_oe_out <= rd_act;
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  amc_state_type state_ff;
  amc_state_type nxt_state;
  logic [7:0]    cnt_ff;
  logic [7:0]    nxt_cnt;
  logic [7:0]    sar_ff;
  logic [7:0]    nxt_sar;
  logic [7:0]    mask_ff;
  logic [7:0]    nxt_mask;
  logic          finish;

  wire step_end  = (cnt_ff == STEP_LAST);
  wire last_step = mask_ff[0];
  // keep the trial bit when the input is at or above the trial level
  wire [7:0] decided = comp_s ? sar_ff : (sar_ff & ~mask_ff);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 8'h01;
    nxt_sar   = sar_ff;
    nxt_mask  = mask_ff;
    finish    = 1'b0;
    unique case (state_ff)
      AMC_NOOP: begin
        nxt_cnt = BYTE_ZERO;
      end
      AMC_SETTLE: begin
        if (cnt_ff == SETTLE_LAST) begin
          nxt_state = AMC_CONVERT;
          nxt_cnt   = BYTE_ZERO;
          nxt_sar   = SAR_TOP;
          nxt_mask  = SAR_TOP;
        end
      end
      AMC_CONVERT: begin
        if (step_end) begin
          nxt_cnt  = BYTE_ZERO;
          nxt_mask = mask_ff >> 1;
          nxt_sar  = decided | (mask_ff >> 1);
          if (last_step) begin
            nxt_state = AMC_NOOP;
            nxt_sar   = decided;
            finish    = 1'b1;
          end
        end
      end
    endcase
    // a fresh start wins over anything in flight
    if (start_ff) begin
      nxt_state = AMC_SETTLE;
      nxt_cnt   = BYTE_ZERO;
      nxt_sar   = BYTE_ZERO;
      nxt_mask  = BYTE_ZERO;
      finish    = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff     <= AMC_NOOP;
      cnt_ff       <= BYTE_ZERO;
      sar_ff       <= BYTE_ZERO;
      mask_ff      <= BYTE_ZERO;
      start_ff     <= 1'b0;
      busy_ff      <= 1'b0;
      settling_out <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      sar_ff       <= nxt_sar;
      mask_ff      <= nxt_mask;
      start_ff     <= sc_written; // start bit clears itself once taken
      busy_ff      <= (nxt_state != AMC_NOOP);
      settling_out <= (nxt_state == AMC_SETTLE);
    end
  end

  // data register holds its value through reset by design
  always_ff @(posedge clk_in) begin
    if (finish) begin
      result_ff <= neg_ge_s ? BYTE_ZERO : decided;
    end
  end

  // finish delayed one clock, so status rises only after the result is stored
  logic fin_d_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fin_d_ff <= 1'b0;
    end else begin
      fin_d_ff <= finish;
    end
  end

  // status sticks through reads; set wins over a full control write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= fin_d_ff ? 1'b1 : (wr_commit ? 1'b0 : done_ff);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign chan_sel_out = channel_ff;
  assign dac_code_out = sar_ff;
  assign port_oe_out  = dir_ff;
  assign busy_out     = busy_ff;
  assign done_out     = done_ff;

endmodule
`default_nettype wire

// ===== test/amc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// analog front end
// ****************
module amc_front_model (
  // converter side
  input  wire logic [7:0] dac_code_in,
  input  wire logic [7:0] level_in,
  output logic            comp_out
);
  // ideal comparator; no offset, so results are exact
  assign comp_out = level_in >= dac_code_in;
endmodule
`default_nettype wire

// ===== test/amc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// amc checks
// ****************
module amc_top_asserts (
  // watched ports
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       cs_n_in,
  input wire logic [7:0] host_data_bus_out,
  input wire logic       host_data_bus_oe_out,
  input wire logic       settling_out,
  input wire logic       busy_out,
  input wire logic       done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // phase ends; past depths tolerate aborts
  sequence s_settle_end;
    $fell(settling_out) && busy_out;
  endsequence
  sequence s_busy_end;
    $fell(busy_out);
  endsequence
  property p_quiet; !host_data_bus_oe_out |-> host_data_bus_out == 8'h00; endproperty
  a_quiet: assert property (p_quiet) else $error("bus not quiet");
  property p_oe; host_data_bus_oe_out |-> !($past(cs_n_in, 2) && $past(cs_n_in, 3) && $past(cs_n_in, 4)); endproperty
  a_oe: assert property (p_oe) else $error("drive without select");
  property p_settle; s_settle_end |-> $past(settling_out, 32); endproperty
  a_settle: assert property (p_settle) else $error("settle short");
  property p_conv; s_busy_end |-> $past(settling_out, 225) && !$past(settling_out, 224); endproperty
  a_conv: assert property (p_conv) else $error("conversion length");
  property p_done; $rose(done_out) |-> $past(busy_out, 2) && !$past(busy_out); endproperty
  a_done: assert property (p_done) else $error("done order");
  property p_done_idle; done_out |-> !busy_out; endproperty
  a_done_idle: assert property (p_done_idle) else $error("done while busy");
  property p_start; $rose(busy_out) |-> settling_out; endproperty
  a_start: assert property (p_start) else $error("no settle first");
  property p_in_busy; settling_out |-> busy_out; endproperty
  a_in_busy: assert property (p_in_busy) else $error("settle idle");
endmodule
bind amc_top amc_top_asserts u_chk (.clk_in, .nrst_in, .cs_n_in, .host_data_bus_out, .host_data_bus_oe_out,
  .settling_out, .busy_out, .done_out);
`default_nettype wire

// ===== test/test_amc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_amc_top;
  logic       clk_in = 0, nrst_in = 0, cs_n = 1, rd = 1, rsel = 0, neg = 0, comp;
  logic [7:0] din = 8'h00, lvl = 8'h00, dout, dac, pdata, m, l;
  logic [5:0] dual = 6'h2B;
  logic [3:0] chan;
  logic       oe, poe, busy, done, settle;
  int         err_count = 0, samples_checked = 0, n;
  amc_top dut (.clk_in, .nrst_in, .cs_n_in(cs_n), .rd_nwr_in(rd), .register_select_line_in(rsel),
    .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe_out(oe), .comp_in(comp),
    .neg_ge_pos_in(neg), .dual_use_inputs_in(dual), .chan_sel_out(chan), .dac_code_out(dac),
    .settling_out(settle), .port_data_out(pdata), .port_oe_out(poe), .busy_out(busy), .done_out(done));
  amc_front_model fe (.dac_code_in(dac), .level_in(lvl), .comp_out(comp));
  // ****************
  // helpers
  // ****************
  task check(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // released bus shows the inverse, so a stale byte cannot pass
  task wr(input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_in);
    cs_n = 0;
    rd = 0;
    din = a;
    @(negedge clk_in);
    din = b;
    @(negedge clk_in);
    cs_n = 1;
    din = ~b;
  endtask
  // bytes are caught whenever the device drives, counted in n
  task rdw(input logic s, input int len);
    @(negedge clk_in);
    cs_n = 0;
    rd = 1;
    rsel = s;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      if (i == len - 1) cs_n = 1;
      if (oe === 1'b1) begin
        if (n == 0) m = dout;
        else l = dout;
        n++;
      end
    end
  endtask
  // bounded waits; n ends as the busy span in clocks
  task meas;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    check(done, 1'b0);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    repeat (2) @(negedge clk_in);
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    check({chan, busy, done, oe, poe}, 16'h0000);
    rdw(1'b1, 2);
    check({m, l}, {2'b00, dual, 8'h00});
    $display("reset done");
  endtask
  task t_conv;
    lvl = 8'hA5;
    wr(8'h3C, 8'h83);
    meas;
    check(16'(n), 16'd256);
    rdw(1'b0, 2);
    check({m, l}, 16'h80A5);
    rdw(1'b0, 1);
    check({8'(n), m}, {8'h01, 8'h80});
    check({pdata, poe, chan}, {8'h3C, 1'b0, 4'h3});
    $display("conv done");
  endtask
  task t_neg;
    neg = 1;
    lvl = 8'hFF;
    dual = 6'h15;
    wr(8'h5A, 8'hCE);
    meas;
    rdw(1'b0, 2);
    check({m, l}, 16'h8000);
    check({pdata, poe, chan}, {8'h5A, 1'b1, 4'hE});
    rdw(1'b1, 2);
    check({m, l}, 16'h150E);
    neg = 0;
    $display("neg done");
  endtask
  task t_abort;
    lvl = 8'h3C;
    wr(8'h00, 8'h81);
    repeat (100) @(negedge clk_in);
    wr(8'h00, 8'h82);
    repeat (6) @(negedge clk_in);
    check({settle, busy}, 2'b11);
    meas;
    rdw(1'b0, 2);
    check({m, l, chan}, {16'h803C, 4'h2});
    $display("abort done");
  endtask
  // mid-run reset aborts the conversion but keeps the last result
  task t_rst2;
    wr(8'h00, 8'h85);
    repeat (50) @(negedge clk_in);
    check({settle, busy, chan}, {2'b01, 4'h5});
    nrst_in = 0;
    repeat (4) @(negedge clk_in);
    nrst_in = 1;
    repeat (2) @(negedge clk_in);
    check({chan, busy, done, settle}, 7'h00);
    rdw(1'b0, 2);
    check({m, l}, 16'h003C);
    $display("mid reset done");
  endtask
  // free running clock
  initial forever #2.5 clk_in = ~clk_in;
  // main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1;
    repeat (2) @(negedge clk_in);
    t_reset;
    t_conv;
    t_neg;
    t_abort;
    t_rst2;
    end_sim;
  end
  // hang guard, several times the expected run
  initial begin
    #20000;
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
